// *** design/alb_link_bringup.sv ***
// Host sequencer that brings up the converter and its serial link
`timescale 1ns/1ns
module alb_link_bringup
  import alb_pkg::*;
#(
  parameter int unsigned POLL_TIMEOUT = POLL_TIMEOUT_CYC
) (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  // Device register port
  output logic dev_req_o,
  output logic dev_we_o,
  output logic [15:0] dev_addr_o,
  output logic [7:0] dev_wdata_o,
  input wire logic dev_ack_i,
  input wire logic [7:0] dev_rdata_i,
  // Board pins
  input wire logic pll_enable_strap_i,
  input wire logic ref_input_select_strap_i,
  input wire logic ref_clock_stable_i,
  input wire logic cal_status_pin_i,
  output logic power_down_pin_o,
  output logic cal_trigger_pin_o,
  // Link receiver and status
  input wire logic rx_link_ready_i,
  output logic busy_o,
  output logic error_o,
  output logic data_valid_o
);

  alb_reg_t r_reg;
  alb_reg_t r_next;
  alb_op_t op;

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0] sel);
    logic [31:0] m;
    m = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        m[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return m;
  endfunction : merge

  // Steps that do not apply to the strapped or chosen configuration
  function automatic logic step_skip(input logic [4:0] s,
                                     input alb_reg_t r);
    logic pll;
    pll = r.s_pll[1];
    case (s)
      ST_PLL_RST, ST_BIAS, ST_PDIV, ST_VDIV, ST_NDIV, ST_OSC_CAL,
      ST_PLL_REL, ST_POLL_OSC, ST_POLL_LOCK: return !pll; // see [RL1]
      ST_TRIM: return !pll || !r.ctrl[CB_MANUAL_TRIM]; // see [RL6]
      ST_TRIG_OUT: return !r.ctrl[CB_TRIGGER_CLOCK_OUT_EN]; // see [RL13]
      ST_OVR: return !r.ctrl[CB_OVERRANGE_ENABLE_BIT];
      ST_PIN_HI: return !r.ctrl[CB_PIN_MODE];
      default: return 1'b0;
    endcase
  endfunction : step_skip

  function automatic alb_op_t step_op(input logic [4:0] s,
                                      input alb_reg_t r);
    alb_op_t o;
    logic pin;
    pin = r.ctrl[CB_PIN_MODE];
    o = '{kind: K_WRITE, addr: DEV_A_RESET, data: DEV_ONE};
    case (s)
      ST_POLL_INIT: o = '{K_POLL, DEV_A_INIT, M_INIT_DONE}; // see [RL4]
      ST_PLL_RST: o = '{K_WRITE, DEV_A_PLL_RST, DEV_ONE}; // see [RL5]
      ST_BIAS: o = '{K_WRITE, DEV_A_BIAS, OSC_BIAS_VAL}; // see [RL5]
      ST_PDIV: o = '{K_WRITE, DEV_A_PDIV, r.cfg_pll[7:0]}; // see [RL6]
      ST_VDIV: o = '{K_WRITE, DEV_A_VDIV, r.cfg_pll[15:8]};
      ST_NDIV: o = '{K_WRITE, DEV_A_NDIV, r.cfg_pll[23:16]};
      ST_TRIM: o = '{K_WRITE, DEV_A_TRIM, r.cfg_pll[31:24]};
      ST_OSC_CAL: o = '{K_WRITE, DEV_A_OSC_CAL,
        r.ctrl[CB_MANUAL_TRIM] ? DEV_ZERO : DEV_ONE}; // see [RL6]
      ST_PLL_REL: o = '{K_WRITE, DEV_A_PLL_RST, DEV_ZERO}; // see [RL7]
      ST_LINK_OFF: o = '{K_WRITE, DEV_A_LINK_EN, DEV_ZERO}; // see [RL8]
      ST_CAL_OFF: o = '{K_WRITE, DEV_A_CAL_EN, DEV_ZERO}; // see [RL9]
      ST_LINK_MODE: o = '{K_WRITE, DEV_A_LINK_MODE, r.cfg_link[7:0]};
      ST_MF_LEN: o = '{K_WRITE, DEV_A_MF_LEN, r.cfg_link[15:8]}; // see [RL10]
      ST_SYNC_SEL: o = '{K_WRITE, DEV_A_SYNC_SEL,
        {7'h00, r.cfg_link[16]}}; // see [RL11], [RL18]
      ST_CAL_CFG_A: o = '{K_WRITE, DEV_A_CAL_CFG_A, r.cfg_cal[7:0]};
      ST_CAL_CFG_B: o = '{K_WRITE, DEV_A_CAL_CFG_B,
        r.cfg_cal[15:8]}; // see [RL12]
      ST_TRIG_OUT: o = '{K_WRITE, DEV_A_TRIG_OUT, r.cfg_cal[23:16]};
      ST_POLL_OSC: o = '{K_POLL, DEV_A_PLL_STAT, M_OSC_DONE}; // see [RL14]
      ST_POLL_LOCK: o = '{K_POLL, DEV_A_PLL_STAT, M_PLL_LOCK}; // see [RL14]
      ST_CAL_ON: o = '{K_WRITE, DEV_A_CAL_EN, DEV_ONE}; // see [RL15]
      ST_OVR: o = '{K_WRITE, DEV_A_OVR, r.cfg_cal[31:24]};
      ST_LINK_ON: o = '{K_WRITE, DEV_A_LINK_EN, DEV_ONE}; // see [RL15]
      ST_TRIG_A: o = pin ? alb_op_t'{K_WRITE, DEV_A_PIN_TRIG_EN, DEV_ONE}
        : alb_op_t'{K_WRITE, DEV_A_SW_TRIG, DEV_ZERO}; // see [RL16]
      ST_TRIG_B: o = pin ? alb_op_t'{K_PIN_LO, DEV_A_RESET, DEV_ZERO}
        : alb_op_t'{K_WRITE, DEV_A_SW_TRIG, DEV_ONE}; // see [RL16]
      ST_PIN_HI: o = '{K_PIN_HI, DEV_A_RESET, DEV_ZERO};
      ST_POLL_FG: o = '{K_POLL, DEV_A_FG_STAT, M_FOREGROUND_DONE_BIT};
      default: o = '{K_WRITE, DEV_A_RESET, DEV_ONE};
    endcase
    return o;
  endfunction : step_op

  assign op = step_op(r_reg.step, r_reg);

  always_comb begin
    logic wb_hit;
    logic start;
    wb_hit = 1'b0;
    start = 1'b0;
    r_next = r_reg;
    // Pin synchronisers
    r_next.s_pll = {r_reg.s_pll[0], pll_enable_strap_i};
    r_next.s_refsel = {r_reg.s_refsel[0], ref_input_select_strap_i};
    r_next.s_clkok = {r_reg.s_clkok[0], ref_clock_stable_i};
    r_next.s_calst = {r_reg.s_calst[0], cal_status_pin_i};

    // Wishbone slave: one wait cycle, ack for one cycle
    r_next.wb_ack = 1'b0;
    if (wb_cyc_i && wb_stb_i && !r_reg.wb_ack) begin
      wb_hit = 1'b1;
      r_next.wb_ack = 1'b1;
    end
    r_next.wb_dat = 32'h0000_0000;
    if (wb_hit && !wb_we_i) begin
      case (wb_adr_i)
        WB_CTRL: r_next.wb_dat = {26'h0, r_reg.ctrl};
        WB_PLL: r_next.wb_dat = r_reg.cfg_pll;
        WB_LINK: r_next.wb_dat = r_reg.cfg_link;
        WB_CAL: r_next.wb_dat = r_reg.cfg_cal;
        WB_STAT: r_next.wb_dat = {19'h0, r_reg.s_refsel[1],
          r_reg.s_pll[1], r_reg.s_calst[1], rx_link_ready_i,
          r_reg.data_valid, r_reg.err_step, r_reg.err, r_reg.done,
          r_reg.busy};
        default: r_next.wb_dat = 32'h0000_0000;
      endcase
    end
    if (wb_hit && wb_we_i) begin
      case (wb_adr_i)
        WB_CTRL: begin
          r_next.ctrl = 6'(merge({26'h0, r_reg.ctrl}, wb_dat_i, wb_sel_i));
          r_next.ctrl[CB_START] = 1'b0;
          start = wb_sel_i[0] && wb_dat_i[CB_START] && !r_reg.busy;
        end
        WB_PLL: r_next.cfg_pll = merge(r_reg.cfg_pll, wb_dat_i, wb_sel_i);
        WB_LINK: r_next.cfg_link = merge(r_reg.cfg_link, wb_dat_i, wb_sel_i);
        WB_CAL: r_next.cfg_cal = merge(r_reg.cfg_cal, wb_dat_i, wb_sel_i);
        default: ;
      endcase
    end

    case (r_reg.st)
      S_IDLE: begin
        if (start) begin
          r_next.busy = 1'b1;
          r_next.done = 1'b0;
          r_next.err = 1'b0;
          r_next.fg_seen = 1'b0;
          r_next.step = ST_RESET;
          r_next.tmo = 32'h0;
          r_next.st = S_CLKWAIT;
        end
      end
      S_CLKWAIT: begin
        if (r_reg.s_clkok[1]) begin // see [RL3]
          r_next.st = S_ISSUE;
        end
      end
      S_ISSUE: begin
        r_next.tmo = 32'(r_reg.tmo + 32'h1);
        if (r_reg.step == ST_END) begin
          r_next.busy = 1'b0;
          r_next.done = 1'b1;
          r_next.st = S_IDLE;
        end else if (step_skip(r_reg.step, r_reg)) begin
          r_next.step = 5'(r_reg.step + 5'h1);
          r_next.tmo = 32'h0;
        end else begin
          case (op.kind)
            K_PIN_LO: begin
              r_next.cal_pin = 1'b0; // see [RL16]
              r_next.pin_cnt = 3'h0;
              r_next.st = S_PINLOW;
            end
            K_PIN_HI: begin
              r_next.cal_pin = 1'b1; // see [RL16]
              r_next.step = 5'(r_reg.step + 5'h1);
            end
            default: begin
              r_next.dev_req = 1'b1;
              r_next.dev_we = (op.kind == K_WRITE);
              r_next.dev_addr = op.addr;
              r_next.dev_wdata = (op.kind == K_WRITE) ? op.data : DEV_ZERO;
              r_next.st = S_BUS;
            end
          endcase
        end
      end
      S_BUS: begin
        r_next.tmo = 32'(r_reg.tmo + 32'h1);
        if (dev_ack_i) begin
          r_next.dev_req = 1'b0;
          r_next.st = S_ISSUE;
          if (r_reg.dev_we || (dev_rdata_i & op.data) != 8'h00) begin
            r_next.step = 5'(r_reg.step + 5'h1);
            r_next.tmo = 32'h0;
            if (r_reg.step == ST_POLL_FG) begin
              r_next.fg_seen = 1'b1;
            end
          end else if (r_reg.tmo >= POLL_TIMEOUT) begin // see [RL20]
            r_next.err = 1'b1;
            r_next.err_step = r_reg.step;
            r_next.busy = 1'b0;
            r_next.st = S_IDLE;
          end
        end
      end
      S_PINLOW: begin
        r_next.pin_cnt = 3'(r_reg.pin_cnt + 3'h1);
        if (r_reg.pin_cnt >= 3'(TRIG_LOW_CYC - 1)) begin
          r_next.step = 5'(r_reg.step + 5'h1);
          r_next.st = S_ISSUE;
        end
      end
      default: r_next.st = S_IDLE;
    endcase

    r_next.pwdn = r_reg.ctrl[CB_POWER_DOWN] && !r_reg.busy; // see [RL2]
    r_next.data_valid = rx_link_ready_i &&
      (r_reg.s_calst[1] || r_reg.fg_seen); // see [RL19]
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_reg <= '0;
      r_reg.cal_pin <= 1'b1;
    end else if (ce_i) begin
      r_reg <= r_next;
    end
  end

  assign wb_ack_o = r_reg.wb_ack;
  assign wb_dat_o = r_reg.wb_dat;
  assign dev_req_o = r_reg.dev_req;
  assign dev_we_o = r_reg.dev_we;
  assign dev_addr_o = r_reg.dev_addr;
  assign dev_wdata_o = r_reg.dev_wdata;
  assign power_down_pin_o = r_reg.pwdn;
  assign cal_trigger_pin_o = r_reg.cal_pin;
  assign busy_o = r_reg.busy;
  assign error_o = r_reg.err;
  assign data_valid_o = r_reg.data_valid;

  // Flags of device writes and polls already acknowledged, for the checks below
  logic h_init_ok, h_pll_rst, h_osc_set, h_link_off, h_cal_off;
  logic h_lock_ok, h_cal_on;
  logic dev_done;
  assign dev_done = dev_req_o && dev_ack_i && ce_i;
  always_ff @(posedge clk_i) begin
    if (rst_i || (r_reg.st == S_IDLE)) begin
      h_init_ok <= 1'b0;
      h_pll_rst <= 1'b0;
      h_osc_set <= 1'b0;
      h_link_off <= 1'b0;
      h_cal_off <= 1'b0;
      h_lock_ok <= 1'b0;
      h_cal_on <= 1'b0;
    end else if (dev_done) begin
      if (!dev_we_o && dev_addr_o == DEV_A_INIT && dev_rdata_i[0]) begin
        h_init_ok <= 1'b1;
      end
      if (!dev_we_o && dev_addr_o == DEV_A_PLL_STAT && dev_rdata_i[1]) begin
        h_lock_ok <= 1'b1;
      end
      if (dev_we_o && dev_addr_o == DEV_A_PLL_RST) begin
        h_pll_rst <= dev_wdata_o[0];
      end
      if (dev_we_o && dev_addr_o == DEV_A_OSC_CAL) begin
        h_osc_set <= 1'b1;
      end
      if (dev_we_o && dev_addr_o == DEV_A_LINK_EN) begin
        h_link_off <= !dev_wdata_o[0];
      end
      if (dev_we_o && dev_addr_o == DEV_A_CAL_EN) begin
        h_cal_off <= !dev_wdata_o[0];
        h_cal_on <= dev_wdata_o[0];
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_pd_low;
    busy_o |-> ##1 !power_down_pin_o;
  endproperty
  a_pd_low: assert property (p_pd_low) // see [RL2]
    else $error("power-down pin high during bring-up");

  property p_req_hold;
    dev_req_o && !dev_ack_i |=> dev_req_o && $stable(dev_addr_o)
      && $stable(dev_we_o) && $stable(dev_wdata_o);
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("device request changed before ack");

  property p_init_first;
    dev_req_o && dev_addr_o != DEV_A_RESET && dev_addr_o != DEV_A_INIT
      |-> h_init_ok;
  endproperty
  a_init_first: assert property (p_init_first) // see [RL4]
    else $error("device access before init-done was seen");

  property p_bias;
    dev_req_o && dev_we_o && dev_addr_o == DEV_A_BIAS
      |-> dev_wdata_o == OSC_BIAS_VAL && h_pll_rst;
  endproperty
  a_bias: assert property (p_bias) // see [RL5]
    else $error("bias write wrong value or PLL not in reset");

  property p_div_in_rst;
    dev_req_o && dev_we_o && (dev_addr_o == DEV_A_PDIV ||
      dev_addr_o == DEV_A_NDIV || dev_addr_o == DEV_A_OSC_CAL)
      |-> h_pll_rst;
  endproperty
  a_div_in_rst: assert property (p_div_in_rst) // see [RL6]
    else $error("divider or trim write outside PLL reset");

  property p_rel_last;
    dev_req_o && dev_we_o && dev_addr_o == DEV_A_PLL_RST
      && dev_wdata_o == DEV_ZERO |-> h_osc_set;
  endproperty
  a_rel_last: assert property (p_rel_last) // see [RL7]
    else $error("PLL reset released before setup");

  property p_link_off;
    dev_req_o && dev_we_o && (dev_addr_o == DEV_A_LINK_MODE ||
      dev_addr_o == DEV_A_MF_LEN || dev_addr_o == DEV_A_SYNC_SEL)
      |-> h_link_off;
  endproperty
  a_link_off: assert property (p_link_off) // see [RL8]
    else $error("link setting written while link enabled");

  property p_cal_off;
    dev_req_o && dev_we_o && (dev_addr_o == DEV_A_CAL_CFG_A ||
      dev_addr_o == DEV_A_CAL_CFG_B) |-> h_cal_off;
  endproperty
  a_cal_off: assert property (p_cal_off) // see [RL9]
    else $error("calibration setting written while enabled");

  property p_lock;
    dev_req_o && dev_we_o && dev_addr_o == DEV_A_CAL_EN
      && dev_wdata_o == DEV_ONE |-> !r_reg.s_pll[1] || h_lock_ok;
  endproperty
  a_lock: assert property (p_lock) // see [RL14]
    else $error("calibration enabled before PLL lock");

  property p_link_last;
    dev_req_o && dev_we_o && dev_addr_o == DEV_A_LINK_EN
      && dev_wdata_o == DEV_ONE |-> h_cal_on;
  endproperty
  a_link_last: assert property (p_link_last) // see [RL15]
    else $error("link enabled before calibration enabled");

  property p_pin;
    $rose(cal_trigger_pin_o) |-> $past(!cal_trigger_pin_o, 2);
  endproperty
  a_pin: assert property (p_pin) // see [RL16]
    else $error("trigger pin low pulse too short");

  property p_valid;
    data_valid_o && $past(ce_i) |-> $past(rx_link_ready_i);
  endproperty
  a_valid: assert property (p_valid) // see [RL19]
    else $error("data valid without link ready");

  property p_tmo;
    $rose(error_o) |-> $past(r_reg.st == S_BUS)
      && $past(r_reg.tmo) >= POLL_TIMEOUT;
  endproperty
  a_tmo: assert property (p_tmo) // see [RL20]
    else $error("error flagged before timeout");

  c_done: cover property ($rose(r_reg.done));
  c_err: cover property ($rose(error_o));
  c_pin: cover property ($rose(cal_trigger_pin_o));
  c_valid: cover property ($rose(data_valid_o));

endmodule : alb_link_bringup

// *** design/alb_pkg.sv ***
// Constants, types and the start-up step list for the link bring-up host
// Bring-up rules for board, host, device and link
// [RL1] Board straps PLL enable and reference select
// [RL2] Power-down pin held low while clocks needed
// [RL3] Stable reference clock before device reset
// [RL4] Soft reset, then poll init-done until 1
// [RL5] PLL reset to 1, then bias 0x4A
// [RL6] Program dividers; auto or manual oscillator trim
// [RL7] Releasing PLL reset is the last PLL step
// [RL8] Link enable to 0 before link changes
// [RL9] Calibration enable to 0 before calibration changes
// [RL10] Program link mode and multiframe length minus one
// [RL11] Program sync source: single-ended or timestamp pins
// [RL12] Configure calibration mode and offset calibration
// [RL13] Optionally configure trigger clock output
// [RL14] With PLL, confirm oscillator done and lock
// [RL15] Calibration on, optional over-range, link on
// [RL16] Foreground calibration: soft trigger or pin pulse
// [RL17] Device raises status pin and done bit
// [RL18] 8b/10b link obeys receiver sync request
// [RL19] Data valid: receiver aligned and calibration done
// [RL20] Every acknowledged poll bounded by timeout, error flagged
package alb_pkg;
  localparam int CLK_FREQ_MHZ = 50;
  localparam int CLK_PERIOD_NS = 20;
  localparam int POLL_TIMEOUT_US = 1000;
  localparam int POLL_TIMEOUT_CYC = POLL_TIMEOUT_US * CLK_FREQ_MHZ;
  localparam int TRIG_LOW_NS = 100;
  localparam int TRIG_LOW_CYC =
    (TRIG_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Wishbone register offsets and control bit positions
  localparam logic [7:0] WB_CTRL = 8'h00;
  localparam logic [7:0] WB_PLL = 8'h04;
  localparam logic [7:0] WB_LINK = 8'h08;
  localparam logic [7:0] WB_CAL = 8'h0c;
  localparam logic [7:0] WB_STAT = 8'h10;
  localparam int CB_START = 0;
  localparam int CB_MANUAL_TRIM = 1;
  localparam int CB_TRIGGER_CLOCK_OUT_EN = 2;
  localparam int CB_OVERRANGE_ENABLE_BIT = 3;
  localparam int CB_PIN_MODE = 4;
  localparam int CB_POWER_DOWN = 5;

  // Device register addresses and values
  localparam logic [15:0] DEV_A_RESET = 16'h0000;
  localparam logic [15:0] DEV_A_INIT = 16'h0001;
  localparam logic [15:0] DEV_A_PLL_RST = 16'h0010;
  localparam logic [15:0] DEV_A_BIAS = 16'h0011;
  localparam logic [15:0] DEV_A_PDIV = 16'h0012;
  localparam logic [15:0] DEV_A_VDIV = 16'h0013;
  localparam logic [15:0] DEV_A_NDIV = 16'h0014;
  localparam logic [15:0] DEV_A_TRIM = 16'h0015;
  localparam logic [15:0] DEV_A_OSC_CAL = 16'h0016;
  localparam logic [15:0] DEV_A_PLL_STAT = 16'h0017;
  localparam logic [15:0] DEV_A_LINK_EN = 16'h0020;
  localparam logic [15:0] DEV_A_CAL_EN = 16'h0021;
  localparam logic [15:0] DEV_A_LINK_MODE = 16'h0022;
  localparam logic [15:0] DEV_A_MF_LEN = 16'h0023;
  localparam logic [15:0] DEV_A_SYNC_SEL = 16'h0024;
  localparam logic [15:0] DEV_A_CAL_CFG_A = 16'h0025;
  localparam logic [15:0] DEV_A_CAL_CFG_B = 16'h0026;
  localparam logic [15:0] DEV_A_TRIG_OUT = 16'h0027;
  localparam logic [15:0] DEV_A_OVR = 16'h0028;
  localparam logic [15:0] DEV_A_SW_TRIG = 16'h0029;
  localparam logic [15:0] DEV_A_PIN_TRIG_EN = 16'h002a;
  localparam logic [15:0] DEV_A_FG_STAT = 16'h002b;
  localparam logic [7:0] DEV_ONE = 8'h01;
  localparam logic [7:0] DEV_ZERO = 8'h00;
  localparam logic [7:0] OSC_BIAS_VAL = 8'h4a;
  localparam logic [7:0] M_INIT_DONE = 8'h01;
  localparam logic [7:0] M_OSC_DONE = 8'h01;
  localparam logic [7:0] M_PLL_LOCK = 8'h02;
  localparam logic [7:0] M_FOREGROUND_DONE_BIT = 8'h01;

  // Step list
  localparam logic [4:0] ST_RESET = 5'h00;
  localparam logic [4:0] ST_POLL_INIT = 5'h01;
  localparam logic [4:0] ST_PLL_RST = 5'h02;
  localparam logic [4:0] ST_BIAS = 5'h03;
  localparam logic [4:0] ST_PDIV = 5'h04;
  localparam logic [4:0] ST_VDIV = 5'h05;
  localparam logic [4:0] ST_NDIV = 5'h06;
  localparam logic [4:0] ST_TRIM = 5'h07;
  localparam logic [4:0] ST_OSC_CAL = 5'h08;
  localparam logic [4:0] ST_PLL_REL = 5'h09;
  localparam logic [4:0] ST_LINK_OFF = 5'h0a;
  localparam logic [4:0] ST_CAL_OFF = 5'h0b;
  localparam logic [4:0] ST_LINK_MODE = 5'h0c;
  localparam logic [4:0] ST_MF_LEN = 5'h0d;
  localparam logic [4:0] ST_SYNC_SEL = 5'h0e;
  localparam logic [4:0] ST_CAL_CFG_A = 5'h0f;
  localparam logic [4:0] ST_CAL_CFG_B = 5'h10;
  localparam logic [4:0] ST_TRIG_OUT = 5'h11;
  localparam logic [4:0] ST_POLL_OSC = 5'h12;
  localparam logic [4:0] ST_POLL_LOCK = 5'h13;
  localparam logic [4:0] ST_CAL_ON = 5'h14;
  localparam logic [4:0] ST_OVR = 5'h15;
  localparam logic [4:0] ST_LINK_ON = 5'h16;
  localparam logic [4:0] ST_TRIG_A = 5'h17;
  localparam logic [4:0] ST_TRIG_B = 5'h18;
  localparam logic [4:0] ST_PIN_HI = 5'h19;
  localparam logic [4:0] ST_POLL_FG = 5'h1a;
  localparam logic [4:0] ST_END = 5'h1b;

  typedef enum logic [1:0] {K_WRITE, K_POLL, K_PIN_LO, K_PIN_HI} alb_kind_t;
  typedef enum logic [2:0] {S_IDLE, S_CLKWAIT, S_ISSUE, S_BUS, S_PINLOW}
    alb_state_t;

  typedef struct packed {
    alb_kind_t kind;
    logic [15:0] addr;
    logic [7:0] data;
  } alb_op_t;

  typedef struct packed {
    alb_state_t st;
    logic [4:0] step;
    logic [31:0] tmo;
    logic [2:0] pin_cnt;
    logic [1:0] s_pll;
    logic [1:0] s_refsel;
    logic [1:0] s_clkok;
    logic [1:0] s_calst;
    logic [5:0] ctrl;
    logic [31:0] cfg_pll;
    logic [31:0] cfg_link;
    logic [31:0] cfg_cal;
    logic wb_ack;
    logic [31:0] wb_dat;
    logic dev_req;
    logic dev_we;
    logic [15:0] dev_addr;
    logic [7:0] dev_wdata;
    logic pwdn;
    logic cal_pin;
    logic busy;
    logic done;
    logic err;
    logic [4:0] err_step;
    logic fg_seen;
    logic data_valid;
  } alb_reg_t;
endpackage : alb_pkg

// *** verif/alb_dev_model.sv ***
// Behavioural converter register file facing the host sequencer
`timescale 1ns/1ns
module alb_dev_model
  import alb_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [1:0] lat_i,
  input wire logic hang_i,
  input wire logic dev_req_i,
  input wire logic dev_we_i,
  input wire logic [15:0] dev_addr_i,
  input wire logic [7:0] dev_wdata_i,
  input wire logic cal_trigger_pin_i,
  output logic dev_ack_o,
  output logic [7:0] dev_rdata_o,
  output logic cal_status_pin_o
);
  logic [7:0] mem [0:63];
  logic [7:0] last;
  logic [1:0] cnt;
  logic pin_q;
  logic [5:0] a;
  logic [23:0] wlog [$];
  int low_run = 0;
  int low_max = 0;
  assign a = dev_addr_i[5:0];
  always @(posedge clk_i) begin
    dev_ack_o <= 1'b0;
    // Idle bus shows the inverse of the last answer, never a stale value
    dev_rdata_o <= ~last;
    pin_q <= cal_trigger_pin_i;
    low_run <= cal_trigger_pin_i ? 0 : low_run + 1;
    if (!cal_trigger_pin_i && low_run >= low_max) begin
      low_max <= low_run + 1;
    end
    if (rst_i) begin
      foreach (mem[i])
        mem[i] <= 8'h00;
      cnt <= 2'h0;
      last <= 8'h00;
      cal_status_pin_o <= 1'b0;
    end else if (dev_req_i && !dev_ack_o) begin
      cnt <= cnt + 2'h1;
      if (cnt >= lat_i) begin
        cnt <= 2'h0;
        dev_ack_o <= 1'b1;
        dev_rdata_o <= dev_we_i ? ~last : mem[a];
        last <= mem[a];
        if (dev_we_i) begin
          wlog.push_back({dev_addr_i, dev_wdata_i});
          mem[a] <= dev_wdata_i;
        end
        if (dev_we_i && a == DEV_A_RESET[5:0]) begin
          mem[DEV_A_INIT[5:0]] <= hang_i ? DEV_ZERO : M_INIT_DONE;
          mem[DEV_A_FG_STAT[5:0]] <= DEV_ZERO;
          cal_status_pin_o <= 1'b0;
        end
        if (dev_we_i && a == DEV_A_PLL_RST[5:0]) begin
          mem[DEV_A_PLL_STAT[5:0]] <= (dev_wdata_i == DEV_ZERO) ?
            (M_OSC_DONE | M_PLL_LOCK) : DEV_ZERO;
        end
        if (dev_we_i && a == DEV_A_SW_TRIG[5:0] && mem[a] == DEV_ZERO &&
            dev_wdata_i == DEV_ONE) begin
          mem[DEV_A_FG_STAT[5:0]] <= M_FOREGROUND_DONE_BIT;
          cal_status_pin_o <= 1'b1;
        end
      end
    end
    if (cal_trigger_pin_i && !pin_q &&
        mem[DEV_A_PIN_TRIG_EN[5:0]] == DEV_ONE) begin
      mem[DEV_A_FG_STAT[5:0]] <= M_FOREGROUND_DONE_BIT;
      cal_status_pin_o <= 1'b1;
    end
  end
endmodule : alb_dev_model

// *** verif/alb_link_bringup_tb.sv ***
// Self-checking bench for the link bring-up host sequencer
`timescale 1ns/1ns
module alb_link_bringup_tb;
  import alb_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, hang = 1'b0;
  logic pll_en = 1'b0, ref_sel = 1'b1, clk_ok = 1'b0, rx_rdy = 1'b0;
  logic ce = 1'b1;
  logic [1:0] lat = 2'h0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic ack, req, dwe, dack, cal_st, pd, trig, busy, err, dval;
  logic [31:0] rdat;
  logic [15:0] daddr;
  logic [7:0] dwd, drd;
  logic [23:0] exp_q [$];
  int bad_count = 0;
  int n_checks = 0;
  always #10 clk_i = ~clk_i;
  alb_link_bringup #(.POLL_TIMEOUT(20)) dut (.clk_i(clk_i), .rst_i(rst_i),
    .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_ack_o(ack),
    .wb_dat_o(rdat), .dev_req_o(req), .dev_we_o(dwe), .dev_addr_o(daddr),
    .dev_wdata_o(dwd), .dev_ack_i(dack), .dev_rdata_i(drd),
    .pll_enable_strap_i(pll_en), .ref_input_select_strap_i(ref_sel),
    .ref_clock_stable_i(clk_ok), .cal_status_pin_i(cal_st),
    .power_down_pin_o(pd), .cal_trigger_pin_o(trig),
    .rx_link_ready_i(rx_rdy), .busy_o(busy), .error_o(err),
    .data_valid_o(dval));
  alb_dev_model dev (.clk_i(clk_i), .rst_i(rst_i), .lat_i(lat),
    .hang_i(hang), .dev_req_i(req), .dev_we_i(dwe), .dev_addr_i(daddr),
    .dev_wdata_i(dwd), .cal_trigger_pin_i(trig), .dev_ack_o(dack),
    .dev_rdata_o(drd), .cal_status_pin_o(cal_st));
  task automatic chk(input string nm, input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 100);
    chk("wb ack", ack, 1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic finish(input string nm, output logic [31:0] q);
    int n;
    n = 0;
    repeat (3) @(posedge clk_i);
    while (busy !== 1'b0 && n < 5000) begin
      @(posedge clk_i);
      n++;
    end
    chk({nm, " idle"}, busy, 0);
    chk({nm, " writes"}, dev.wlog.size(), exp_q.size());
    foreach (exp_q[i]) chk(nm, dev.wlog[i], {8'h0, exp_q[i]});
    wb(1'b0, WB_STAT, 32'h0, q);
  endtask : finish
  task automatic t_regs;
    logic [31:0] q;
    chk("trig idle", trig, 1);
    chk("pd idle", pd, 0);
    wb(1'b1, 8'h3c, 32'hffffffff, q);
    wb(1'b0, 8'h3c, 32'h0, q);
    chk("unmapped", q, 0);
    wb(1'b1, WB_PLL, 32'h9c0c0402, q);
    wb(1'b0, WB_PLL, 32'h0, q);
    chk("pll reg", q, 32'h9c0c0402);
    wb(1'b1, WB_LINK, 32'h00011f08, q);
    wb(1'b1, WB_CAL, 32'h33810b0a, q);
    wb(1'b1, WB_CTRL, 32'h20, q);
    repeat (2) @(posedge clk_i);
    chk("pd on", pd, 1);
    wb(1'b1, WB_CTRL, 32'h0, q);
    wb(1'b0, WB_STAT, 32'h0, q);
    chk("stat", q, 32'h1000);
    $display("test regs done");
  endtask : t_regs
  task automatic t_soft;
    logic [31:0] q;
    exp_q = '{24'h000001, 24'h002000, 24'h002100, 24'h002208, 24'h00231f,
      24'h002401, 24'h00250a, 24'h00260b, 24'h002101, 24'h002001,
      24'h002900, 24'h002901};
    wb(1'b1, WB_CTRL, 32'h1, q);
    repeat (20) @(posedge clk_i);
    chk("clock wait", dev.wlog.size(), 0);
    ce <= 1'b0;
    clk_ok <= 1'b1;
    repeat (10) @(posedge clk_i);
    chk("ce hold", dev.wlog.size(), 0);
    ce <= 1'b1;
    finish("soft", q);
    chk("soft stat", q[2:0], 3'h2);
    chk("valid no rx", dval, 0);
    rx_rdy <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk("valid", dval, 1);
    $display("test soft trigger done");
  endtask : t_soft
  task automatic t_pll;
    logic [31:0] q;
    pll_en <= 1'b1;
    lat <= 2'h3;
    exp_q = '{24'h000001, 24'h001001, 24'h00114a, 24'h001202, 24'h001304,
      24'h00140c, 24'h00159c, 24'h001600, 24'h001000, 24'h002000,
      24'h002100, 24'h002208, 24'h00231f, 24'h002401, 24'h00250a,
      24'h00260b, 24'h002781, 24'h002101, 24'h002833, 24'h002001,
      24'h002a01};
    dev.wlog.delete();
    repeat (3) @(posedge clk_i);
    wb(1'b1, WB_CTRL, 32'h1f, q);
    finish("pll", q);
    chk("pll stat", q[2:0], 3'h2);
    chk("pin low", dev.low_max, TRIG_LOW_CYC + 1);
    chk("cal pin", cal_st, 1);
    $display("test pll and pin trigger done");
  endtask : t_pll
  task automatic t_tmo;
    logic [31:0] q;
    hang <= 1'b1;
    lat <= 2'h0;
    exp_q = '{24'h000001};
    dev.wlog.delete();
    wb(1'b1, WB_CTRL, 32'h1, q);
    finish("tmo", q);
    chk("err pin", err, 1);
    chk("err stat", q[7:0], {ST_POLL_INIT, 3'h4});
    $display("test timeout done");
  endtask : t_tmo
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_soft();
    t_pll();
    t_tmo();
    wrap_up();
  end
  initial begin
    #400000;
    bad_count++;
    wrap_up();
  end
endmodule : alb_link_bringup_tb
